/* File: rtl/sticky_flags.v */
// Group of sticky flags in which a hardware set wins over a clear.
`timescale 1ns/1ps
module sticky_flags #(
  parameter WIDTH = 1             // Number of flags.
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst,
  // Events and clears
  input  wire [WIDTH-1:0] set,
  input  wire [WIDTH-1:0] clr,
  // Flag state
  output reg  [WIDTH-1:0] q
);

  // A set in the same cycle as a clear keeps the flag, so no event is lost.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= {WIDTH{1'b0}};
    end else begin
      q <= (q & ~clr) | set;
    end
  end

endmodule

/* File: rtl/sync2.v */
// Two flip-flop synchroniser for a level arriving from a pin.
`timescale 1ns/1ps
module sync2 #(
  parameter RESET_VAL = 1'b0      // Level held during reset.
) (
  // Clock and reset
  input  wire clk,
  input  wire rst,
  // Level in and out
  input  wire d,
  output reg  q
);

  reg meta;                       // First stage, read only by the second.

  // Two stages; only the second one is visible to logic.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= RESET_VAL;
      q    <= RESET_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

/* File: rtl/usb_ctrl_defines.vh */
// Constants shared by the USB device control and status block.
// What this block does
// - Bus reset detection sets reset flag.
// - USB reset clears address and endpoint 0 toggle and status bits.
// - Start-of-frame token sets frame flag.
// - Flag, mask set and CPU unmasked: interrupt.
// - Control register resets to 06h.
// - Control bits 7, 6 show resume, reset seen.
// - Resume bit drives resume signalling; software times it.
// - Power-down bit switches regulator off.
// - Forced suspend cleared by bus activity.
// - Forced reset holds link; release raises reset.
// - Address register holds 7 bits, bit 7 zero.
// - Status captures upper token bits for endpoint 0.
// - Completed transfer records endpoint; direction only for endpoints 1 to 3.
// - Error code stored, cleared with error flag.
// - USB reset clears endpoint 0 bits 6:4, 2:0.
// - Correct endpoint 0 transaction sets done bit.
// - SETUP sets transmit toggle, clears receive toggle.
// - Receive toggle flips on matching data packet.
// - Two-bit status: disabled, stall, NAK, valid.
// - Correct endpoint 0 transfer sets both NAK.
// - SETUP acknowledged gives NAK; STALL answer gives STALL.
// - Bus activity in suspend sets wake flag.
// - Over 3 ms idle sets idle request.
`ifndef USB_CTRL_DEFINES_VH
`define USB_CTRL_DEFINES_VH

// Register byte offsets on the bus.
`define OFF_FLAGS        8'h00
`define OFF_MASK         8'h04
`define OFF_CTRL         8'h08
`define OFF_ADDR         8'h0C
`define OFF_STATUS       8'h10
`define OFF_EP0          8'h14

// Reset values.
`define RST_MASK         8'h00
`define RST_CTRL         8'h06
`define RST_ADDR         7'h00
`define RST_STATUS       8'h00

// Flag register bit positions (the mask register uses the same layout).
`define FLG_DONE         7
`define FLG_SOVR         5
`define FLG_ERR          4
`define FLG_IDLE         3
`define FLG_WAKE         2
`define FLG_RESET        1
`define FLG_SOF          0

// Control register bit positions.
`define CTL_RESUME_SEEN  7
`define CTL_RESET_SEEN   6
`define CTL_RESUME       3
`define CTL_REG_OFF      2
`define CTL_SUSPEND      1
`define CTL_HOLD         0

// Endpoint status field encodings.
`define STAT_DISABLED    2'h0
`define STAT_STALL       2'h1
`define STAT_NAK         2'h2
`define STAT_VALID       2'h3

// Token identifier upper bits.
`define PID_SETUP        2'h3

// Idle time before a suspend request, and the clock rate.
`define IDLE_TIME_MS     3
`define CLK_KHZ          200000
`define IDLE_CYCLES      (`IDLE_TIME_MS * `CLK_KHZ)

`endif

/* File: rtl/usb_device_control_status.v */
// Control, status, mask, address and control-endpoint logic of a USB device.
`timescale 1ns/1ps
`include "usb_ctrl_defines.vh"
module usb_device_control_status #(
  parameter IDLE_CYCLES = `IDLE_CYCLES, // Idle cycles before a suspend request.
  parameter CNT_W       = 20            // Width of the idle counter.
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  // Line state from the transceiver pin
  input  wire        line_idle,
  // Events from the serial engine, one-cycle pulses on this clock
  input  wire        ev_bus_reset,
  input  wire        ev_resume,
  input  wire        ev_sof,
  input  wire        ev_xfer_ok,
  input  wire [1:0]  xfer_ep,
  input  wire        xfer_in,
  input  wire [1:0]  xfer_pid,
  input  wire        ev_tx_ack,
  input  wire        ev_rx_match,
  input  wire        ev_stall_sent,
  input  wire        ev_err,
  input  wire [2:0]  err_code,
  // CPU global interrupt mask
  input  wire        cpu_int_masked,
  // Interrupt requests
  output reg         irq_usb,
  output reg         irq_wake,
  // Link controls
  output reg         resume_drive,
  output reg         regulator_off,
  output reg         forced_suspend,
  output reg         link_hold_reset,
  output reg  [6:0]  function_address,
  // Endpoint 0 settings seen by the engine
  output reg         tx_toggle,
  output reg  [1:0]  tx_stat,
  output reg         rx_toggle,
  output reg  [1:0]  rx_stat
);

  // Bus side state.
  reg        wr_pend;             // A write data phase is due.
  reg  [7:0] wr_addr;             // Byte address of the pending write.
  wire       addr_phase;          // A transfer is offered this cycle.
  wire       we_flags;            // Write strobes per register.
  wire       we_mask;
  wire       we_ctrl;
  wire       we_addr;
  wire       we_ep0;
  wire [7:0] wdat;                // Low byte of the write data.

  // Register state.
  reg  [7:0] interrupt_enable_mask; // Enable bits, same layout as the flags.
  reg        resume_seen;         // Resume signalling started.
  reg        reset_seen;          // Reset signalling started.
  reg  [7:0] transaction_status;  // Last token, endpoint, direction, error.
  reg        hold_prev;           // Forced reset value one cycle ago.
  reg  [CNT_W-1:0] idle_cnt;      // Continuous idle time counter.
  wire       idle_s;              // Synchronised idle level.
  wire [5:0] flag_q;              // Sticky flags, bits 5 to 0 of the flag register.
  wire [5:0] flag_set;            // Hardware sets of the sticky flags.
  wire [5:0] flag_clr;            // Software clears of the sticky flags.
  wire       ctrl_ep_done;        // Endpoint 0 completed transfer.
  wire       ep0_done_clr;        // Software clear of that bit.
  wire       transfer_done_any;   // Or of all completed-transfer flags.
  wire [7:0] interrupt_flags;     // Flag register as read.
  wire [7:0] link_control;        // Control register as read.
  wire [7:0] control_endpoint_ctrl; // Endpoint 0 register as read.

  // Derived events.
  wire usb_rst;                   // Received or forced USB reset.
  wire ep0_done;                  // Correct transfer on endpoint 0.
  wire ep12_done;                 // Correct transfer on endpoint 1, 2 or 3.
  wire setup_overrun;             // SETUP done while the last is unserviced.
  wire ep0_record;                // Endpoint 0 transfer that updates status.
  wire is_setup;                  // Completed token was SETUP.
  wire activity;                  // Bus is not idle.
  wire wake;                      // Activity ends a forced suspend.
  wire idle_hit;                  // Idle time just exceeded.
  wire err_cleared;               // Error flag cleared by software.

  // The idle level comes from a pin and is synchronised first.
  sync2 #(
    .RESET_VAL (1'b1)
  ) u_idle_sync (
    .clk (clk),
    .rst (rst),
    .d   (line_idle),
    .q   (idle_s)
  );

  assign activity = ~idle_s;

  // Address phase is taken whenever the bus is ready, the slave selected and htrans[1] is set.
  assign addr_phase = hsel & hready & htrans[1];

  // The write lands in its data phase, one cycle after the address phase.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= addr_phase & hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_phase) begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  assign wdat     = hwdata[7:0];
  assign we_flags = wr_pend & (wr_addr == `OFF_FLAGS);
  assign we_mask  = wr_pend & (wr_addr == `OFF_MASK);
  assign we_ctrl  = wr_pend & (wr_addr == `OFF_CTRL);
  assign we_addr  = wr_pend & (wr_addr == `OFF_ADDR);
  assign we_ep0   = wr_pend & (wr_addr == `OFF_EP0);

  // A forced reset clears the address and endpoint 0 state just like a received one.
  assign usb_rst = ev_bus_reset | link_hold_reset;

  // Classify completed transfers.
  assign ep0_done      = ev_xfer_ok & (xfer_ep == 2'h0);
  assign ep12_done     = ev_xfer_ok & (xfer_ep != 2'h0);
  assign is_setup      = (xfer_pid == `PID_SETUP);
  assign setup_overrun = ep0_done & is_setup & ctrl_ep_done;
  assign ep0_record    = ep0_done & ~setup_overrun;

  // Forced suspend ends on bus activity.
  assign wake = forced_suspend & activity;

  // The suspend request fires once, when the count first passes the limit.
  assign idle_hit = (idle_cnt == IDLE_CYCLES[CNT_W-1:0] - 1'b1);

  // Hardware events for the sticky flags.
  assign flag_set[5] = setup_overrun;
  assign flag_set[4] = ev_err;
  assign flag_set[3] = idle_hit;
  assign flag_set[2] = wake;
  assign flag_set[1] = ev_bus_reset | (hold_prev & ~link_hold_reset);
  assign flag_set[0] = ev_sof;

  // Writing a zero clears a flag, writing a one leaves it.
  assign flag_clr = we_flags ? ~wdat[5:0] : 6'h00;

  // Interrupt event flags; a set in a clearing cycle survives.
  sticky_flags #(
    .WIDTH (6)
  ) u_flags (
    .clk (clk),
    .rst (rst),
    .set (flag_set),
    .clr (flag_clr),
    .q   (flag_q)
  );

  // Endpoint 0 done is cleared by a zero written to bit 7.
  assign ep0_done_clr = we_ep0 & ~wdat[7];

  // Completed transfer bit of endpoint 0, untouched by USB reset.
  sticky_flags #(
    .WIDTH (1)
  ) u_ep0_done (
    .clk (clk),
    .rst (rst),
    .set (ep0_done),
    .clr (ep0_done_clr),
    .q   (ctrl_ep_done)
  );

  // Only endpoint 0 has a done bit here, so the summary is that bit.
  assign transfer_done_any = ctrl_ep_done;

  assign interrupt_flags = {transfer_done_any, 1'b0, flag_q};

  // The error code clears when software clears the error flag.
  assign err_cleared = we_flags & ~wdat[`FLG_ERR] & ~ev_err;

  // Interrupt requests, registered so the outputs come from flip-flops.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_usb  <= 1'b0;
      irq_wake <= 1'b0;
    end else begin
      // All events but wake share one request line.
      irq_usb  <= (|(interrupt_flags & interrupt_enable_mask & 8'hFB))
                  & ~cpu_int_masked;
      // Wake has its own line so it can rouse a halted processor.
      irq_wake <= interrupt_flags[`FLG_WAKE] & interrupt_enable_mask[`FLG_WAKE]
                  & ~cpu_int_masked;
    end
  end

  // Mask register, read and write; bit 6 always stays zero.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      interrupt_enable_mask <= `RST_MASK;
    end else if (we_mask) begin
      interrupt_enable_mask <= wdat & 8'hBF;
    end
  end

  // Control register: software bits plus hardware status bits.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      resume_drive    <= 1'b0;
      regulator_off   <= 1'b1;
      forced_suspend  <= 1'b1;
      link_hold_reset <= 1'b0;
      hold_prev       <= 1'b0;
      resume_seen     <= 1'b0;
      reset_seen      <= 1'b0;
    end else begin
      hold_prev <= link_hold_reset;
      if (we_ctrl) begin
        resume_drive    <= wdat[`CTL_RESUME];
        regulator_off   <= wdat[`CTL_REG_OFF];
        link_hold_reset <= wdat[`CTL_HOLD];
      end
      // Hardware activity clears forced suspend over any software write.
      if (wake) begin
        forced_suspend <= 1'b0;
      end else if (we_ctrl) begin
        forced_suspend <= wdat[`CTL_SUSPEND];
      end
      // The cause bits are cleared when a new suspend is entered.
      if (ev_resume) begin
        resume_seen <= 1'b1;
      end else if (we_ctrl & wdat[`CTL_SUSPEND] & ~forced_suspend) begin
        resume_seen <= 1'b0;
      end
      if (ev_bus_reset) begin
        reset_seen <= 1'b1;
      end else if (we_ctrl & wdat[`CTL_SUSPEND] & ~forced_suspend) begin
        reset_seen <= 1'b0;
      end
    end
  end

  assign link_control = {resume_seen, reset_seen, 2'b00, resume_drive,
                         regulator_off, forced_suspend, link_hold_reset};

  // Idle counter; restarts on reset or activity and is off in forced suspend.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_cnt <= {CNT_W{1'b0}};
    end else if (usb_rst | activity | forced_suspend) begin
      idle_cnt <= {CNT_W{1'b0}};
    end else if (idle_cnt != IDLE_CYCLES[CNT_W-1:0]) begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  // Device address register, seven bits, cleared by a USB reset.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      function_address <= `RST_ADDR;
    end else if (usb_rst) begin
      function_address <= `RST_ADDR;
    end else if (we_addr) begin
      function_address <= wdat[6:0];
    end
  end

  // Transaction status register, written only by hardware.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      transaction_status <= `RST_STATUS;
    end else begin
      if (ep0_record) begin
        transaction_status[7:6] <= xfer_pid;
        transaction_status[4:3] <= 2'h0;
      end else if (ep12_done) begin
        transaction_status[5]   <= xfer_in;
        transaction_status[4:3] <= xfer_ep;
      end
      if (ev_err) begin
        transaction_status[2:0] <= err_code;
      end else if (err_cleared) begin
        transaction_status[2:0] <= 3'h0;
      end
    end
  end

  // Endpoint 0 toggles; reset first, then hardware events, then software.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_toggle <= 1'b0;
      rx_toggle <= 1'b0;
    end else if (usb_rst) begin
      tx_toggle <= 1'b0;
      rx_toggle <= 1'b0;
    end else if (ep0_done & is_setup) begin
      tx_toggle <= 1'b1;
      rx_toggle <= 1'b0;
    end else begin
      if (ev_tx_ack) begin
        tx_toggle <= ~tx_toggle;
      end else if (we_ep0) begin
        tx_toggle <= wdat[6];
      end
      if (ev_rx_match) begin
        rx_toggle <= ~rx_toggle;
      end else if (we_ep0) begin
        rx_toggle <= wdat[2];
      end
    end
  end

  // Endpoint 0 status fields; the engine obeys their encoding.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_stat <= `STAT_DISABLED;
      rx_stat <= `STAT_DISABLED;
    end else if (usb_rst) begin
      tx_stat <= `STAT_DISABLED;
      rx_stat <= `STAT_DISABLED;
    end else if (ev_stall_sent) begin
      tx_stat <= `STAT_STALL;
      rx_stat <= `STAT_STALL;
    end else if (ep0_done) begin
      tx_stat <= `STAT_NAK;
      rx_stat <= `STAT_NAK;
    end else if (we_ep0) begin
      tx_stat <= wdat[5:4];
      rx_stat <= wdat[1:0];
    end
  end

  assign control_endpoint_ctrl = {ctrl_ep_done, tx_toggle, tx_stat, 1'b0,
                                  rx_toggle, rx_stat};

  // Read data is registered in the address phase; unmapped reads give zero.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase & ~hwrite) begin
      case (haddr[7:0])
        `OFF_FLAGS:  hrdata <= {24'h00_0000, interrupt_flags};
        `OFF_MASK:   hrdata <= {24'h00_0000, interrupt_enable_mask};
        `OFF_CTRL:   hrdata <= {24'h00_0000, link_control};
        `OFF_ADDR:   hrdata <= {24'h00_0000, 1'b0, function_address};
        `OFF_STATUS: hrdata <= {24'h00_0000, transaction_status};
        `OFF_EP0:    hrdata <= {24'h00_0000, control_endpoint_ctrl};
        default:     hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the USB device control and status block.
`timescale 1ns/1ps
`include "usb_ctrl_defines.vh"
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        cpu_int_masked = 1'b1;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [7:0]  q;
  wire         hready, hreadyout, hresp, line_idle, ev_bus_reset, ev_resume, ev_sof;
  wire         ev_xfer_ok, xfer_in, ev_tx_ack, ev_rx_match, ev_stall_sent, ev_err;
  wire         irq_usb, irq_wake, resume_drive, regulator_off, forced_suspend;
  wire         link_hold_reset, tx_toggle, rx_toggle;
  wire [31:0]  hrdata;
  wire [1:0]   xfer_ep, xfer_pid, tx_stat, rx_stat;
  wire [2:0]   err_code;
  wire [6:0]   function_address;
  int          errors = 0;
  int          checks_done = 0;
  localparam logic [7:0] E_RST = 8'h80, E_RES = 8'h40, E_SOF = 8'h20, E_XFR = 8'h10;
  localparam logic [7:0] E_ACK = 8'h08, E_MAT = 8'h04, E_STL = 8'h02, E_ERR = 8'h01;

  always #2.5 clk = ~clk;
  assign hready = hreadyout; // The one slave drives the bus ready.

  usb_device_control_status #(.IDLE_CYCLES(50), .CNT_W(20)) i_usb_device_control_status (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .line_idle(line_idle), .ev_bus_reset(ev_bus_reset),
    .ev_resume(ev_resume), .ev_sof(ev_sof), .ev_xfer_ok(ev_xfer_ok), .xfer_ep(xfer_ep),
    .xfer_in(xfer_in), .xfer_pid(xfer_pid), .ev_tx_ack(ev_tx_ack), .ev_rx_match(ev_rx_match),
    .ev_stall_sent(ev_stall_sent), .ev_err(ev_err), .err_code(err_code),
    .cpu_int_masked(cpu_int_masked), .irq_usb(irq_usb), .irq_wake(irq_wake),
    .resume_drive(resume_drive), .regulator_off(regulator_off),
    .forced_suspend(forced_suspend), .link_hold_reset(link_hold_reset),
    .function_address(function_address), .tx_toggle(tx_toggle), .tx_stat(tx_stat),
    .rx_toggle(rx_toggle), .rx_stat(rx_stat));

  usb_host_model i_usb_host_model (
    .clk(clk), .line_idle(line_idle), .ev_bus_reset(ev_bus_reset), .ev_resume(ev_resume),
    .ev_sof(ev_sof), .ev_xfer_ok(ev_xfer_ok), .xfer_ep(xfer_ep), .xfer_in(xfer_in),
    .xfer_pid(xfer_pid), .ev_tx_ack(ev_tx_ack), .ev_rx_match(ev_rx_match),
    .ev_stall_sent(ev_stall_sent), .ev_err(ev_err), .err_code(err_code));

  // Counts a comparison and reports a mismatch.
  task chk(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t ns: got %0h, expected %0h", $time, got, exp);
    end
  endtask
  // One single AHB-Lite transfer; read data lands in q.
  task xf(input w, input [7:0] a, input [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata[7:0];
  endtask
  task w(input [7:0] a, input [7:0] d);
    xf(1'b1, a, d);
  endtask
  // Reads a register and compares the bits under the mask.
  task rc(input [7:0] a, input [7:0] m, input [7:0] e);
    xf(1'b0, a, 8'h00);
    chk(q & m, e);
  endtask
  task evt(input [7:0] e);
    i_usb_host_model.pulse(e, 2'h0, 1'b0, 2'h0, 3'h0);
  endtask
  task xfr(input [1:0] ep, input in, input [1:0] pid);
    i_usb_host_model.pulse(E_XFR, ep, in, pid, 3'h0);
  endtask

  task t_reset;
    rc(`OFF_FLAGS, 8'hFF, 8'h00);
    rc(`OFF_MASK, 8'hFF, `RST_MASK);
    rc(`OFF_CTRL, 8'hFF, `RST_CTRL);
    rc(`OFF_ADDR, 8'hFF, 8'h00);
    rc(`OFF_STATUS, 8'hFF, `RST_STATUS);
    rc(`OFF_EP0, 8'hFF, 8'h00);
    rc(8'h18, 8'hFF, 8'h00);
    chk({regulator_off, forced_suspend, link_hold_reset, hresp}, 4'b1100);
  endtask
  task t_ctrl;
    w(`OFF_CTRL, 8'hF4);
    #1;
    chk({resume_drive, regulator_off, forced_suspend, link_hold_reset}, 4'h4);
    rc(`OFF_CTRL, 8'hFF, 8'h04);
    w(`OFF_CTRL, 8'h00);
    #1;
    chk(regulator_off, 1'b0);
    repeat (600) @(posedge clk);
  endtask
  task t_irq;
    w(`OFF_MASK, 8'hFF);
    rc(`OFF_MASK, 8'hFF, 8'hBF);
    w(`OFF_MASK, 8'h01);
    evt(E_SOF);
    repeat (2) @(posedge clk);
    #1;
    chk(irq_usb, 1'b0);
    rc(`OFF_FLAGS, 8'h01, 8'h01);
    @(posedge clk);
    cpu_int_masked <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(irq_usb, 1'b1);
    w(`OFF_FLAGS, 8'hFF);
    rc(`OFF_FLAGS, 8'h01, 8'h01);
    w(`OFF_FLAGS, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk(irq_usb, 1'b0);
  endtask
  task t_ep0;
    static logic [1:0] pids [3] = '{2'h0, 2'h2, `PID_SETUP};
    foreach (pids[i]) begin
      w(`OFF_EP0, 8'h33);
      xfr(2'h0, 1'b0, pids[i]);
      rc(`OFF_STATUS, 8'hF8, {pids[i], 6'h00});
      rc(`OFF_EP0, 8'hB3, 8'hA2);
    end
    rc(`OFF_EP0, 8'h44, 8'h40);
    xfr(2'h0, 1'b0, `PID_SETUP);
    rc(`OFF_FLAGS, 8'hA0, 8'hA0);
    evt(E_ACK);
    evt(E_MAT);
    rc(`OFF_EP0, 8'h44, 8'h04);
    evt(E_STL);
    rc(`OFF_EP0, 8'h33, 8'h11);
    w(`OFF_EP0, 8'h7F);
    rc(`OFF_EP0, 8'hFF, 8'h77);
    chk({tx_toggle, tx_stat, rx_toggle, rx_stat}, 6'h3F);
    xfr(2'h1, 1'b1, 2'h0);
    rc(`OFF_STATUS, 8'h38, 8'h28);
    xfr(2'h2, 1'b0, 2'h0);
    rc(`OFF_STATUS, 8'h38, 8'h10);
  endtask
  task t_err;
    static logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    foreach (codes[i]) begin
      i_usb_host_model.pulse(E_ERR, 2'h0, 1'b0, 2'h0, codes[i]);
      rc(`OFF_STATUS, 8'h07, {5'h00, codes[i]});
      w(`OFF_FLAGS, 8'hEF);
      rc(`OFF_STATUS, 8'h07, 8'h00);
    end
  endtask
  task t_addr;
    w(`OFF_ADDR, 8'hFF);
    rc(`OFF_ADDR, 8'hFF, 8'h7F);
    chk(function_address, 7'h7F);
    evt(E_RST);
    rc(`OFF_ADDR, 8'hFF, 8'h00);
    w(`OFF_ADDR, 8'h55);
    w(`OFF_EP0, 8'h77);
    xfr(2'h0, 1'b0, 2'h0);
    w(`OFF_FLAGS, 8'h00);
    w(`OFF_CTRL, 8'h01);
    #1;
    chk(link_hold_reset, 1'b1);
    rc(`OFF_ADDR, 8'hFF, 8'h00);
    rc(`OFF_EP0, 8'hFF, 8'h80);
    rc(`OFF_FLAGS, 8'h02, 8'h00);
    w(`OFF_CTRL, 8'h00);
    rc(`OFF_FLAGS, 8'h02, 8'h02);
  endtask
  task t_idle;
    w(`OFF_FLAGS, 8'h00);
    evt(E_RST);
    rc(`OFF_FLAGS, 8'h0A, 8'h02);
    rc(`OFF_CTRL, 8'h40, 8'h40);
    repeat (50) @(posedge clk);
    rc(`OFF_FLAGS, 8'h08, 8'h08);
    w(`OFF_FLAGS, 8'h00);
    evt(E_RST);
    w(`OFF_CTRL, 8'h02);
    repeat (60) @(posedge clk);
    rc(`OFF_FLAGS, 8'h08, 8'h00);
  endtask
  task t_wake;
    w(`OFF_MASK, 8'h04);
    w(`OFF_CTRL, 8'h0A);
    #1;
    chk(resume_drive, 1'b1);
    w(`OFF_CTRL, 8'h02);
    evt(E_RES);
    i_usb_host_model.busy(4);
    repeat (3) @(posedge clk);
    #1;
    chk({forced_suspend, irq_wake, resume_drive}, 3'b010);
    rc(`OFF_FLAGS, 8'h04, 8'h04);
    rc(`OFF_CTRL, 8'hC0, 8'h80);
  endtask
  // Prints the counts and the verdict, then stops.
  task end_sim;
    $display("errors %0d, checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence after a reset of 20 cycles.
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset;
    t_ctrl;
    t_irq;
    t_ep0;
    t_err;
    t_addr;
    t_idle;
    t_wake;
    end_sim;
  end
  // Watchdog, far beyond the cycles the tests need.
  initial begin
    #100000;
    errors++;
    end_sim;
  end
endmodule

/* File: verif/usb_ctrl_sva.sv */
// Assertions on the event and link ports of the USB control block.
`timescale 1ns/1ps
`include "usb_ctrl_defines.vh"
module usb_ctrl_sva (
  // Clock and reset
  input logic       clk,
  input logic       rst,
  // Far-side events and CPU mask
  input logic       line_idle,
  input logic       ev_bus_reset,
  input logic       ev_xfer_ok,
  input logic [1:0] xfer_ep,
  input logic [1:0] xfer_pid,
  input logic       ev_tx_ack,
  input logic       ev_rx_match,
  input logic       ev_stall_sent,
  input logic       cpu_int_masked,
  // Outputs under check
  input logic       irq_usb,
  input logic       irq_wake,
  input logic       forced_suspend,
  input logic       link_hold_reset,
  input logic [6:0] function_address,
  input logic       tx_toggle,
  input logic [1:0] tx_stat,
  input logic       rx_toggle,
  input logic [1:0] rx_stat
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // A USB reset, received or forced.
  wire usb_rst = ev_bus_reset | link_hold_reset;
  // A correct endpoint 0 transfer, and a SETUP among them, not beaten by a reset.
  wire ep0_done = ev_xfer_ok & (xfer_ep == 2'h0) & ~usb_rst;
  wire setup = ep0_done & (xfer_pid == `PID_SETUP);

  bus_reset_clear_a: assert property (
    usb_rst |=> function_address == 7'h00 && tx_stat == `STAT_DISABLED
      && rx_stat == `STAT_DISABLED && !tx_toggle && !rx_toggle)
    else $error("USB reset left endpoint 0 or the address set");
  stall_both_a: assert property (
    ev_stall_sent && !usb_rst |=> tx_stat == `STAT_STALL && rx_stat == `STAT_STALL)
    else $error("STALL answer did not stall both directions");
  done_nak_a: assert property (
    ep0_done && !ev_stall_sent |=> tx_stat == `STAT_NAK && rx_stat == `STAT_NAK)
    else $error("endpoint 0 transfer did not set both NAK");
  setup_toggle_a: assert property (
    setup |=> tx_toggle && !rx_toggle)
    else $error("SETUP did not set the toggles");
  tx_flip_a: assert property (
    ev_tx_ack && !usb_rst && !setup |=> tx_toggle != $past(tx_toggle))
    else $error("transmit toggle did not flip on ACK");
  rx_flip_a: assert property (
    ev_rx_match && !usb_rst && !setup |=> rx_toggle != $past(rx_toggle))
    else $error("receive toggle did not flip on a match");
  irq_gate_a: assert property (
    cpu_int_masked |=> !irq_usb && !irq_wake)
    else $error("interrupt raised while the CPU mask was set");
  wake_clear_a: assert property (
    $fell(line_idle) && forced_suspend |-> ##[1:5] !forced_suspend)
    else $error("bus activity did not end forced suspend");
endmodule
bind usb_device_control_status usb_ctrl_sva i_usb_ctrl_sva (
  .clk(clk), .rst(rst), .line_idle(line_idle), .ev_bus_reset(ev_bus_reset),
  .ev_xfer_ok(ev_xfer_ok), .xfer_ep(xfer_ep), .xfer_pid(xfer_pid), .ev_tx_ack(ev_tx_ack),
  .ev_rx_match(ev_rx_match), .ev_stall_sent(ev_stall_sent), .cpu_int_masked(cpu_int_masked),
  .irq_usb(irq_usb), .irq_wake(irq_wake), .forced_suspend(forced_suspend),
  .link_hold_reset(link_hold_reset), .function_address(function_address),
  .tx_toggle(tx_toggle), .tx_stat(tx_stat), .rx_toggle(rx_toggle), .rx_stat(rx_stat)
);

/* File: verif/usb_host_model.sv */
// Behavioural far side: line state and event pulses caused by host traffic.
`timescale 1ns/1ps
module usb_host_model (
  // Clock
  input  wire        clk,
  // Line state, 1 while the bus idles
  output logic       line_idle,
  // Event pulses and their qualifiers
  output wire        ev_bus_reset,
  output wire        ev_resume,
  output wire        ev_sof,
  output wire        ev_xfer_ok,
  output wire  [1:0] xfer_ep,
  output wire        xfer_in,
  output wire  [1:0] xfer_pid,
  output wire        ev_tx_ack,
  output wire        ev_rx_match,
  output wire        ev_stall_sent,
  output wire        ev_err,
  output wire  [2:0] err_code
);
  logic [7:0] evs  = 8'h00; // One bit for each event kind.
  logic [7:0] qual = 8'h00; // Qualifiers of the event in flight.
  assign {ev_bus_reset, ev_resume, ev_sof, ev_xfer_ok} = evs[7:4];
  assign {ev_tx_ack, ev_rx_match, ev_stall_sent, ev_err} = evs[3:0];
  assign {xfer_ep, xfer_in, xfer_pid, err_code} = qual;
  initial line_idle = 1'b1;
  // One cycle of events; the qualifiers then flip, as they mean nothing between events.
  task pulse(input [7:0] e, input [1:0] ep, input in, input [1:0] pid, input [2:0] c);
    @(posedge clk);
    evs  <= e;
    qual <= {ep, in, pid, c};
    @(posedge clk);
    evs  <= 8'h00;
    qual <= ~{ep, in, pid, c};
  endtask
  // Bus activity for n cycles, then the bus idles again.
  task busy(input int n);
    @(posedge clk);
    line_idle <= 1'b0;
    repeat (n) @(posedge clk);
    line_idle <= 1'b1;
  endtask
endmodule
